// *** verilog/css_pkg.sv ***
// Package with offsets, field positions, reset values and timing for the clock select block
package css_pkg;
  localparam int          CSS_AW          = 4;
  localparam logic [3:0]  CSS_SEL_ADDR    = 4'h0;
  localparam logic [3:0]  CSS_STAT_ADDR   = 4'h1;
  localparam int          CSS_CHOOSE_BIT  = 7;
  localparam int          CSS_KEEP_BIT    = 6;
  localparam int          CSS_KIND_BIT    = 5;
  localparam int          CSS_PLL_HALT    = 3;
  localparam int          CSS_TICK_HALT   = 1;
  localparam int          CSS_DOG_HALT    = 0;
  localparam logic [7:0]  CSS_WRITE_MASK  = 8'hcb;
  localparam logic [7:0]  CSS_RESET_VAL   = 8'h00;
  localparam logic [7:0]  CSS_ZERO        = 8'h00;
  localparam int          CSS_BUS_DIV     = 2;
  localparam logic [2:0]  CSS_STAT_STABLE = 3'h0;
  localparam logic [2:0]  CSS_STAT_STOP   = 3'h1;
  localparam logic [2:0]  CSS_STAT_WAIT   = 3'h2;
endpackage : css_pkg

// *** verilog/css_mode_if.sv ***
// Interface carrying low power mode events from the mode tracker to the register
`timescale 1ns/1ps
interface css_mode_if;
  logic wait_enter;
  logic stop_enter;
  logic self_enter;
  logic in_wait;
  logic in_stop;
  modport src (output wait_enter, output stop_enter, output self_enter, output in_wait,
               output in_stop);
  modport dst (input wait_enter, input stop_enter, input self_enter, input in_wait,
               input in_stop);
endinterface : css_mode_if

// *** verilog/css_mode_track.sv ***
// Mode entry edge detector for wait, stop and self clock modes
`timescale 1ns/1ps
module css_mode_track (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic wait_req,
  input  wire logic stop_req,
  input  wire logic self_clock_req,
  css_mode_if.src   mode
);
  logic wait_d_r;
  logic stop_d_r;
  logic self_d_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_d_r <= 1'h0;
      stop_d_r <= 1'h0;
      self_d_r <= 1'h0;
    end
    else
    begin
      wait_d_r <= wait_req;
      stop_d_r <= stop_req;
      self_d_r <= self_clock_req;
    end
  end

  assign mode.wait_enter = wait_req & ~wait_d_r;
  assign mode.stop_enter = stop_req & ~stop_d_r;
  assign mode.self_enter = self_clock_req & ~self_d_r;
  assign mode.in_wait    = wait_req;
  assign mode.in_stop    = stop_req;
endmodule : css_mode_track

// *** verilog/css_clock_select.sv ***
// Clock source select register with low power mode side effects
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module css_clock_select (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        pll_locked,
  input  wire logic        oscillator_kind_status,
  input  wire logic        special_mode,
  input  wire logic        pll_power_on,
  input  wire logic        wait_req,
  input  wire logic        stop_req,
  input  wire logic        self_clock_req,
  output logic             pll_clock_choose,
  output logic             oscillator_run,
  output logic             pll_powered,
  output logic             tick_timer_run,
  output logic             tick_timer_reinit,
  output logic             watchdog_run,
  output logic             watchdog_reinit
);
  //////////////////////////////////////////////////////////////////////////////
  css_mode_if mode ();

  css_mode_track css_mode_track_inst (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .wait_req       (wait_req),
    .stop_req       (stop_req),
    .self_clock_req (self_clock_req),
    .mode           (mode)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic       pll_sel_r;
  logic       osc_keep_r;
  logic       pll_halt_r;
  logic       tick_halt_r;
  logic       dog_halt_r;
  logic       dog_written_r;
  logic [7:0] rdata_nxt;
  logic       sel_wr;
  logic       stat_rd;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction : hit

  assign sel_wr = reg_wr & hit(reg_addr, css_pkg::CSS_SEL_ADDR);
  assign stat_rd = reg_rd & hit(reg_addr, css_pkg::CSS_STAT_ADDR);

  // PLL select with lock guard and low power clearing
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pll_sel_r <= 1'h0;
    else if (mode.self_enter | mode.stop_enter | (mode.wait_enter & pll_halt_r))
      pll_sel_r <= 1'h0;
    else if (mode.in_wait & pll_halt_r)
      pll_sel_r <= 1'h0;
    else if (sel_wr)
    begin
      if (reg_wdata[css_pkg::CSS_CHOOSE_BIT] & pll_locked)
        pll_sel_r <= 1'h1;
      else if (!reg_wdata[css_pkg::CSS_CHOOSE_BIT])
        pll_sel_r <= 1'h0;
    end
  end

  // Anytime writable control bits
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_keep_r  <= 1'h0;
      pll_halt_r  <= 1'h0;
      tick_halt_r <= 1'h0;
    end
    else if (sel_wr)
    begin
      osc_keep_r  <= reg_wdata[css_pkg::CSS_KEEP_BIT];
      pll_halt_r  <= reg_wdata[css_pkg::CSS_PLL_HALT];
      tick_halt_r <= reg_wdata[css_pkg::CSS_TICK_HALT];
    end
  end

  // Watchdog halt bit, write once in normal modes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dog_halt_r    <= 1'h0;
      dog_written_r <= 1'h0;
    end
    else if (sel_wr && (special_mode || !dog_written_r))
    begin
      dog_halt_r    <= reg_wdata[css_pkg::CSS_DOG_HALT];
      dog_written_r <= 1'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb
  begin
    rdata_nxt = css_pkg::CSS_ZERO;
    if (reg_rd && hit(reg_addr, css_pkg::CSS_SEL_ADDR))
    begin
      rdata_nxt[css_pkg::CSS_CHOOSE_BIT] = pll_sel_r;
      rdata_nxt[css_pkg::CSS_KEEP_BIT]   = osc_keep_r;
      rdata_nxt[css_pkg::CSS_KIND_BIT]   = oscillator_kind_status;
      rdata_nxt[css_pkg::CSS_PLL_HALT]   = pll_halt_r;
      rdata_nxt[css_pkg::CSS_TICK_HALT]  = tick_halt_r;
      rdata_nxt[css_pkg::CSS_DOG_HALT]   = dog_halt_r;
    end
    else if (stat_rd)
    begin
      rdata_nxt[css_pkg::CSS_STAT_STABLE] = pll_locked;
      rdata_nxt[css_pkg::CSS_STAT_STOP]   = mode.in_stop;
      rdata_nxt[css_pkg::CSS_STAT_WAIT]   = mode.in_wait;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= css_pkg::CSS_ZERO;
    else
      reg_rdata <= rdata_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock and halt controls
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pll_clock_choose  <= 1'h0;
      oscillator_run    <= 1'h1;
      pll_powered       <= 1'h0;
      tick_timer_run    <= 1'h1;
      tick_timer_reinit <= 1'h0;
      watchdog_run      <= 1'h1;
      watchdog_reinit   <= 1'h0;
    end
    else
    begin
      pll_clock_choose  <= pll_sel_r;
      oscillator_run    <= ~mode.in_stop | osc_keep_r;
      pll_powered       <= pll_power_on & ~(mode.in_wait & pll_halt_r);
      tick_timer_run    <= ~(mode.in_wait & tick_halt_r);
      tick_timer_reinit <= mode.wait_enter & tick_halt_r;
      watchdog_run      <= ~(mode.in_wait & dog_halt_r);
      watchdog_reinit   <= mode.wait_enter & dog_halt_r;
    end
  end
endmodule : css_clock_select

// *** sim/css_clock_select_monitor.sv ***
// Checker watching the clock select register ports
`timescale 1ns/1ps
module css_clock_select_monitor (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pll_locked,
  input wire logic       pll_power_on,
  input wire logic       wait_req,
  input wire logic       stop_req,
  input wire logic       self_clock_req,
  input wire logic       pll_clock_choose,
  input wire logic       oscillator_run,
  input wire logic       pll_powered,
  input wire logic       tick_timer_run,
  input wire logic       watchdog_run
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_LOCK: assert property ($rose(pll_clock_choose) |-> $past(pll_locked, 2))
    else $error("select rose while unlocked");
  AST_SET: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[7] && pll_locked
    && !wait_req && !stop_req && !self_clock_req ##1 !wait_req && !stop_req && !self_clock_req
    |=> pll_clock_choose) else $error("select not taken");
  AST_STOP: assert property ($rose(stop_req) || $rose(self_clock_req)
    |-> ##[1:4] !pll_clock_choose) else $error("select kept on entry");
  AST_WAIT: assert property ((wait_req && pll_power_on && !pll_powered)[*2]
    |-> !pll_clock_choose) else $error("select kept in wait");
  AST_OSC: assert property ((!stop_req)[*4] |-> oscillator_run)
    else $error("oscillator off outside stop");
  AST_TICK: assert property ((!wait_req)[*4] |-> tick_timer_run)
    else $error("tick timer halted outside wait");
  AST_DOG: assert property ((!wait_req)[*4] |-> watchdog_run)
    else $error("watchdog halted outside wait");
  AST_RSV: assert property ($past(reg_rd && reg_addr == 4'h0)
    |-> !reg_rdata[4] && !reg_rdata[2]) else $error("reserved bit set");
  cover property ($rose(pll_clock_choose));
  cover property ($fell(oscillator_run));
  cover property ($fell(watchdog_run));
endmodule : css_clock_select_monitor
bind css_clock_select css_clock_select_monitor css_clock_select_monitor_inst (.sys_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pll_locked, .pll_power_on, .wait_req,
  .stop_req, .self_clock_req, .pll_clock_choose, .oscillator_run, .pll_powered,
  .tick_timer_run, .watchdog_run);

// *** sim/css_clock_select_bench.sv ***
// Bench driving the clock select register through its access port
`timescale 1ns/1ps
module css_clock_select_bench;
  logic       sys_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pll_locked = 1'h0;
  logic       special_mode = 1'h0, wait_req = 1'h0, stop_req = 1'h0, self_clock_req = 1'h0;
  logic       pll_power_on = 1'h1, oscillator_kind_status = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, lv;
  logic       pll_clock_choose, oscillator_run, pll_powered, tick_timer_run, watchdog_run;
  logic       tick_timer_reinit, watchdog_reinit;
  int         n_mismatch = 0, checks = 0;
  int         n_tick_reinit = 0, n_dog_reinit = 0;
  assign lv = {3'h0, pll_clock_choose, oscillator_run, pll_powered, tick_timer_run, watchdog_run};
  css_clock_select css_clock_select_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pll_locked, .oscillator_kind_status, .special_mode,
    .pll_power_on, .wait_req, .stop_req, .self_clock_req, .pll_clock_choose,
    .oscillator_run, .pll_powered, .tick_timer_run, .tick_timer_reinit, .watchdog_run,
    .watchdog_reinit);
  initial forever #5 sys_clk = ~sys_clk;
  // Count one-cycle reinit pulses
  always @(posedge sys_clk)
  begin
    if (tick_timer_reinit === 1'h1)
      n_tick_reinit <= n_tick_reinit + 1;
    if (watchdog_reinit === 1'h1)
      n_dog_reinit <= n_dog_reinit + 1;
  end
  ////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task md(input logic w, input logic s, input logic c);
    @(posedge sys_clk);
    wait_req <= w;
    stop_req <= s;
    self_clock_req <= c;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : md
  task finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  initial
  begin
    #20000;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    rd(4'h0, 8'h20);
    chk(lv, 8'h0f);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h6b);
    @(posedge sys_clk) pll_locked <= 1'h1;
    wr(4'h0, 8'h80);
    rd(4'h0, 8'ha1);
    chk(lv, 8'h1f);
    wr(4'h0, 8'hca);
    md(1'h1, 1'h0, 1'h0);
    chk(lv, 8'h08);
    chk(n_tick_reinit[7:0], 8'h01);
    chk(n_dog_reinit[7:0], 8'h01);
    wr(4'h0, 8'hca);
    rd(4'h0, 8'h6b);
    md(1'h0, 1'h0, 1'h0);
    rd(4'h0, 8'h6b);
    wr(4'h0, 8'hc0);
    md(1'h0, 1'h1, 1'h0);
    chk(lv, 8'h0f);
    rd(4'h1, 8'h03);
    md(1'h0, 1'h0, 1'h0);
    rd(4'h0, 8'h61);
    wr(4'h0, 8'h80);
    md(1'h0, 1'h1, 1'h0);
    chk(lv, 8'h07);
    md(1'h0, 1'h0, 1'h0);
    wr(4'h0, 8'h80);
    md(1'h0, 1'h0, 1'h1);
    rd(4'h0, 8'h21);
    @(posedge sys_clk) special_mode <= 1'h1;
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h20);
    wr(4'h0, 8'h80);
    md(1'h1, 1'h0, 1'h0);
    chk(lv, 8'h1f);
    chk(n_tick_reinit[7:0], 8'h01);
    chk(n_dog_reinit[7:0], 8'h01);
    @(posedge sys_clk)
    begin
      pll_power_on <= 1'h0;
      oscillator_kind_status <= 1'h0;
    end
    md(1'h0, 1'h0, 1'h0);
    chk(lv, 8'h1b);
    rd(4'h0, 8'h80);
    rd(4'h5, 8'h00);
    finish_test;
  end
endmodule : css_clock_select_bench
